// file: sitm_top.sv
// Safety input and test stop monitor, top level.
// Assumes inputs synchronous to clk_sys; all outputs registered.
`timescale 1ns/1ps
module sitm_top #(
  parameter int MS_CYCLES = sitm_pkg::MS_CYCLES
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [sitm_pkg::DI_N-1:0] di_term_a,
  input wire logic [sitm_pkg::DI_N-1:0] di_term_b,
  input wire logic readback_raw,
  input wire logic [15:0] discrepancy_window,
  input wire logic [15:0] input_filter_time,
  input wire logic [sitm_pkg::SRC_W-1:0] torque_off_source,
  input wire logic [sitm_pkg::SRC_W-1:0] stop_one_source,
  input wire logic [sitm_pkg::SRC_W-1:0] brake_source,
  input wire logic link_in_use,
  input wire logic link_ok,
  input wire logic [2:0] link_loss_reaction,
  input wire logic ext_torque_off_sel,
  input wire logic ext_stop_one_sel,
  input wire logic direction_unselected,
  input wire logic direction_sel,
  input wire logic speed_unselected,
  input wire logic speed_sel,
  input wire logic encoder_present,
  input wire logic switched_on,
  input wire logic [31:0] basic_test_interval,
  input wire logic [31:0] extended_test_interval,
  input wire logic test_trigger_source,
  input wire logic auto_test_on_rampup,
  input wire logic rampup_done,
  input wire logic internal_fault,
  input wire logic limit_violation,
  input wire logic fault_ack,
  output logic torque_off_function,
  output logic ramped_stop_one,
  output logic brake_control_safe,
  output logic [2:0] stop_reaction,
  output logic direction_guard,
  output logic limited_speed_guard,
  output logic discrepancy_fault,
  output logic source_error,
  output logic test_fail,
  output logic safety_fault,
  output logic internal_event,
  output logic comm_failure,
  output logic [31:0] basic_status_word,
  output logic [31:0] extended_status_word,
  output logic [31:0] basic_time_left,
  output logic [31:0] extended_time_left,
  output logic test_due_alarm
);

  localparam int N = sitm_pkg::DI_N;
  localparam int MSW = $clog2(MS_CYCLES + 1);
  localparam logic [MSW-1:0] MS_LAST = MSW'(MS_CYCLES - 1);
  localparam logic [9:0] SEC_LAST = 10'(sitm_pkg::SEC_MS - 1);

  // Selection from a source code; an illegal code selects, failing safe
  function automatic logic src_sel(
    input logic [sitm_pkg::SRC_W-1:0] src,
    input logic [N-1:0] lvl
  );
    if (src == sitm_pkg::SRC_ZERO) begin
      src_sel = 1'b0;
    end else if (!src_legal(src)) begin
      src_sel = 1'b1;
    end else begin
      src_sel = lvl[src];
    end
  endfunction : src_sel

  function automatic logic src_legal(
    input logic [sitm_pkg::SRC_W-1:0] src
  );
    if (src == sitm_pkg::SRC_ZERO) begin
      src_legal = 1'b1;
    end else if (32'(src) >= N) begin
      src_legal = 1'b0;
    end else begin
      src_legal = sitm_pkg::SRC_LEGAL[src];
    end
  endfunction : src_legal

  ////////////////////////////////////////////////////////////////////////
  // Time base

  logic [MSW-1:0] ms_cnt_q;
  logic [9:0] sec_cnt_q;
  logic ms_tick_q;
  logic sec_tick_q;

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      ms_cnt_q <= '0;
      ms_tick_q <= 1'b0;
    end else begin
      ms_tick_q <= (ms_cnt_q == MS_LAST);
      ms_cnt_q <= (ms_cnt_q == MS_LAST) ? '0 : ms_cnt_q + 1'b1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      sec_cnt_q <= 10'h000;
      sec_tick_q <= 1'b0;
    end else begin
      sec_tick_q <= ms_tick_q && (sec_cnt_q == SEC_LAST);
      if (ms_tick_q) begin
        sec_cnt_q <= (sec_cnt_q == SEC_LAST) ? 10'h000 : sec_cnt_q + 10'h001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Input channels

  // Filter value latched once rounded, so channels never see fractions
  logic [15:0] filter_ms_q;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      filter_ms_q <= 16'h0000;
    end else begin
      filter_ms_q <= sitm_pkg::round_ms(input_filter_time);
    end
  end

  wire logic [N-1:0] di_level;
  wire logic [N-1:0] di_disc;
  wire logic readback_level;

  for (genvar i = 0; i < N; i++) begin : g_di
    sitm_chan u_chan (
      .clk_sys(clk_sys),
      .sys_rst(sys_rst),
      .ms_tick(ms_tick_q),
      .term_a(di_term_a[i]),
      .term_b(di_term_b[i]),
      .filter_ms(filter_ms_q),
      .window_ms(discrepancy_window),
      .hold(ext_torque_off_sel),
      .level_q(di_level[i]),
      .disc_fault_q(di_disc[i])
    );
  end

  // Single readback line: both terminals tied, discrepancy never runs
  sitm_chan u_readback (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .ms_tick(ms_tick_q),
    .term_a(readback_raw),
    .term_b(readback_raw),
    .filter_ms(filter_ms_q),
    .window_ms(discrepancy_window),
    .hold(1'b1),
    .level_q(readback_level),
    .disc_fault_q()
  );

  ////////////////////////////////////////////////////////////////////////
  // Selections and link supervision

  wire logic sto_term = src_sel(torque_off_source, di_level);
  wire logic ss1_term = src_sel(stop_one_source, di_level);
  wire logic sbc_term = src_sel(brake_source, di_level);
  wire logic src_bad = !src_legal(torque_off_source) ||
                       !src_legal(stop_one_source) ||
                       !src_legal(brake_source);
  wire logic link_lost = link_in_use && !link_ok;
  wire logic [2:0] reaction_d = link_lost ? link_loss_reaction
                                          : sitm_pkg::STOP_NONE;
  wire logic cut_by_link = link_lost &&
    (link_loss_reaction == sitm_pkg::STOP_PULSE_CUT);
  wire logic ramp_by_link = link_lost &&
    (link_loss_reaction == sitm_pkg::STOP_RAMPED);
  wire logic sto_sel = sto_term || ext_torque_off_sel;

  // Power-on marker: guards without a source start from here with encoder
  logic powered_q;
  logic sto_sel_q;
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      powered_q <= 1'b0;
      sto_sel_q <= 1'b0;
    end else begin
      powered_q <= 1'b1;
      sto_sel_q <= sto_sel;
    end
  end
  wire logic power_up_pulse = !powered_q;
  wire logic sto_deselect = sto_sel_q && !sto_sel;
  wire logic guard_base = encoder_present ? powered_q : switched_on;
  wire logic dir_d = direction_unselected ? guard_base
                                          : direction_sel;
  wire logic sls_d = speed_unselected ? guard_base
                                      : speed_sel;

  ////////////////////////////////////////////////////////////////////////
  // Extended forced check sequence

  sitm_pkg::sitm_test_st_t tst_q;
  sitm_pkg::sitm_test_st_t tst_d;
  logic [15:0] wait_q;
  logic trig_q;
  logic ramp_q;
  logic fail_d;

  wire logic trig_rise = test_trigger_source && !trig_q;
  wire logic ramp_rise = rampup_done && !ramp_q;
  wire logic test_start = auto_test_on_rampup ? ramp_rise
                                              : trig_rise;
  wire logic wait_over = (wait_q >= sitm_pkg::TEST_WAIT_MS);
  wire logic test_forcing = (tst_q == sitm_pkg::TST_FORCE);
  wire logic test_busy = (tst_q != sitm_pkg::TST_IDLE);
  wire logic ext_done = (tst_q == sitm_pkg::TST_DONE);

  // Readback high means the shutdown path has opened
  always_comb begin
    tst_d = tst_q;
    fail_d = 1'b0;
    case (tst_q)
      sitm_pkg::TST_IDLE: begin
        if (test_start) begin
          tst_d = sitm_pkg::TST_FORCE;
        end
      end
      sitm_pkg::TST_FORCE: begin
        if (readback_level) begin
          tst_d = sitm_pkg::TST_RELEASE;
        end else if (wait_over) begin
          tst_d = sitm_pkg::TST_IDLE;
          fail_d = 1'b1;
        end
      end
      sitm_pkg::TST_RELEASE: begin
        if (!readback_level) begin
          tst_d = sitm_pkg::TST_DONE;
        end else if (wait_over) begin
          tst_d = sitm_pkg::TST_IDLE;
          fail_d = 1'b1;
        end
      end
      sitm_pkg::TST_DONE: begin
        tst_d = sitm_pkg::TST_IDLE;
      end
      default: begin
        tst_d = sitm_pkg::TST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      tst_q <= sitm_pkg::TST_IDLE;
      trig_q <= 1'b0;
      ramp_q <= 1'b0;
      wait_q <= 16'h0000;
    end else begin
      tst_q <= tst_d;
      trig_q <= test_trigger_source;
      ramp_q <= rampup_done;
      if (tst_d != tst_q) begin
        wait_q <= 16'h0000;
      end else if (ms_tick_q) begin
        wait_q <= wait_q + 16'h0001;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Test interval timers

  wire logic basic_restart = power_up_pulse || sto_deselect ||
                             ext_done;
  wire logic ext_restart = power_up_pulse || sto_deselect || ext_done;
  wire logic basic_due;
  wire logic ext_due;

  sitm_test_timer u_basic_timer (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .sec_tick(sec_tick_q),
    .restart(basic_restart),
    .interval_s(basic_test_interval),
    .time_left_q(basic_time_left),
    .due_q(basic_due)
  );

  sitm_test_timer u_ext_timer (
    .clk_sys(clk_sys),
    .sys_rst(sys_rst),
    .sec_tick(sec_tick_q),
    .restart(ext_restart),
    .interval_s(extended_test_interval),
    .time_left_q(extended_time_left),
    .due_q(ext_due)
  );

  ////////////////////////////////////////////////////////////////////////
  // Faults and events

  wire logic disc_any = |di_disc;
  wire logic fault_set = disc_any || internal_fault || limit_violation ||
                         fail_d || src_bad;
  wire logic message_set = fault_set || link_lost ||
                           basic_due || ext_due;

  // Sticky flags: a new event in the ack cycle wins over the clear
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      safety_fault <= 1'b0;
      internal_event <= 1'b0;
      test_fail <= 1'b0;
    end else begin
      safety_fault <= fault_set || (safety_fault && !fault_ack);
      internal_event <= message_set ||
                        (internal_event && !fault_ack);
      test_fail <= fail_d || (test_fail && !fault_ack);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Registered outputs

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      torque_off_function <= 1'b0;
      ramped_stop_one <= 1'b0;
      brake_control_safe <= 1'b0;
      stop_reaction <= sitm_pkg::STOP_NONE;
      direction_guard <= 1'b0;
      limited_speed_guard <= 1'b0;
      discrepancy_fault <= 1'b0;
      source_error <= 1'b0;
      comm_failure <= 1'b0;
      test_due_alarm <= 1'b0;
    end else begin
      torque_off_function <= sto_sel || cut_by_link ||
                             test_forcing;
      ramped_stop_one <= ss1_term || ext_stop_one_sel || ramp_by_link;
      brake_control_safe <= sbc_term;
      stop_reaction <= reaction_d;
      direction_guard <= dir_d;
      limited_speed_guard <= sls_d;
      discrepancy_fault <= disc_any;
      source_error <= src_bad;
      comm_failure <= link_lost;
      test_due_alarm <= basic_due || ext_due;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      basic_status_word <= 32'h00000000;
      extended_status_word <= 32'h00000000;
    end else begin
      basic_status_word <= 32'h00000000;
      basic_status_word[sitm_pkg::BASIC_DUE_BIT] <= basic_due;
      basic_status_word[sitm_pkg::BASIC_STO_BIT] <= sto_sel;
      extended_status_word <= 32'h00000000;
      extended_status_word[sitm_pkg::EXT_DUE_BIT] <= ext_due;
      extended_status_word[sitm_pkg::EXT_TEST_BIT] <= test_busy;
    end
  end

endmodule : sitm_top

// file: sitm_pkg.sv
// Constants shared by the safety input and test stop monitor.
// Assumes one 100 MHz clock and synchronous, active-high reset.
package sitm_pkg;

  localparam int CLK_PERIOD_NS = 10;
  localparam int MS_PERIOD_NS = 1000000;
  localparam int MS_CYCLES = MS_PERIOD_NS / CLK_PERIOD_NS;
  localparam int SEC_MS = 1000;

  localparam int DI_N = 22;
  localparam int SRC_W = 5;
  localparam logic [SRC_W-1:0] SRC_ZERO = 5'h1F;
  localparam logic [DI_N-1:0] SRC_LEGAL = 22'h3300FF;

  localparam logic [15:0] DISC_WINDOW_MS = 16'h01F4;
  localparam logic [15:0] FILTER_ROUND_HALF = 16'h0032;
  localparam logic [15:0] FILTER_UNITS_PER_MS = 16'h0064;
  localparam logic [15:0] TEST_WAIT_MS = 16'h0064;

  localparam logic [2:0] STOP_NONE = 3'h7;
  localparam logic [2:0] STOP_PULSE_CUT = 3'h0;
  localparam logic [2:0] STOP_RAMPED = 3'h1;

  localparam int BASIC_DUE_BIT = 31;
  localparam int BASIC_STO_BIT = 0;
  localparam int EXT_DUE_BIT = 0;
  localparam int EXT_TEST_BIT = 1;

  typedef enum logic [3:0] {
    TST_IDLE = 4'b0001,
    TST_FORCE = 4'b0010,
    TST_RELEASE = 4'b0100,
    TST_DONE = 4'b1000
  } sitm_test_st_t;

  function automatic logic [15:0] round_ms(input logic [15:0] hundredths);
    logic [16:0] sum;
    sum = {1'b0, hundredths} + {1'b0, FILTER_ROUND_HALF};
    round_ms = 16'(sum / {1'b0, FILTER_UNITS_PER_MS});
  endfunction : round_ms

endpackage : sitm_pkg

// file: sitm_chan.sv
// Two-terminal failsafe input: debounce plus discrepancy timing.
// Assumes a one-cycle millisecond tick from the top level.
`timescale 1ns/1ps
module sitm_chan (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic ms_tick,
  input wire logic term_a,
  input wire logic term_b,
  input wire logic [15:0] filter_ms,
  input wire logic [15:0] window_ms,
  input wire logic hold,
  output logic level_q,
  output logic disc_fault_q
);
  logic [1:0] stb_q;
  logic [15:0] deb_q [2];
  logic [15:0] disc_q;
  wire logic [1:0] raw = {term_b, term_a};
  wire logic agree = (stb_q[0] == stb_q[1]);

  for (genvar t = 0; t < 2; t++) begin : g_term
    // Accept a change only once it outlasts the filter time
    always_ff @(posedge clk_sys) begin
      if (sys_rst) begin
        stb_q[t] <= 1'b0;
        deb_q[t] <= 16'h0000;
      end else if (raw[t] == stb_q[t]) begin
        deb_q[t] <= 16'h0000;
      end else if (deb_q[t] >= filter_ms) begin
        stb_q[t] <= raw[t];
        deb_q[t] <= 16'h0000;
      end else if (ms_tick) begin
        deb_q[t] <= deb_q[t] + 16'h0001;
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      level_q <= 1'b0;
      disc_q <= 16'h0000;
      disc_fault_q <= 1'b0;
    end else if (agree || hold) begin
      disc_q <= 16'h0000;
      disc_fault_q <= 1'b0;
      if (agree) begin
        level_q <= stb_q[0];
      end
    end else if (disc_q >= window_ms) begin
      disc_fault_q <= 1'b1;
    end else if (ms_tick) begin
      disc_q <= disc_q + 16'h0001;
    end
  end
endmodule : sitm_chan

// file: sitm_test_timer.sv
// Forced check interval timer counting whole seconds.
// Assumes a one-cycle second tick and a restart pulse.
`timescale 1ns/1ps
module sitm_test_timer (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic sec_tick,
  input wire logic restart,
  input wire logic [31:0] interval_s,
  output logic [31:0] time_left_q,
  output logic due_q
);
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      time_left_q <= 32'h00000000;
      due_q <= 1'b0;
    end else if (restart) begin
      time_left_q <= interval_s;
      due_q <= 1'b0;
    end else if (sec_tick) begin
      if (time_left_q == 32'h00000000) begin
        due_q <= 1'b1;
      end else begin
        time_left_q <= time_left_q - 32'h00000001;
      end
    end
  end
endmodule : sitm_test_timer

// file: sitm_top_assertions.sv
// Port-level checker for the safety input and test stop monitor.
// Assumes one clock domain and synchronous active-high reset.
`timescale 1ns/1ps
module sitm_top_chk #(
  parameter int MS_CYCLES = sitm_pkg::MS_CYCLES
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic link_in_use,
  input wire logic link_ok,
  input wire logic [2:0] link_loss_reaction,
  input wire logic ext_torque_off_sel,
  input wire logic direction_unselected,
  input wire logic speed_unselected,
  input wire logic encoder_present,
  input wire logic switched_on,
  input wire logic internal_fault,
  input wire logic torque_off_function,
  input wire logic [2:0] stop_reaction,
  input wire logic direction_guard,
  input wire logic limited_speed_guard,
  input wire logic discrepancy_fault,
  input wire logic safety_fault,
  input wire logic internal_event,
  input wire logic comm_failure,
  input wire logic [31:0] basic_status_word,
  input wire logic [31:0] extended_status_word,
  input wire logic [31:0] basic_time_left,
  input wire logic test_due_alarm
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////
  // Link lost with a steady reaction code
  sequence s_lost;
    link_in_use && !link_ok && $stable(link_loss_reaction);
  endsequence
  sequence s_lost_held;
    s_lost [*3];
  endsequence
  a_stop_code: assert property (s_lost_held |->
    stop_reaction == link_loss_reaction) else $error("stop code wrong");
  a_pulse_cut: assert property (s_lost_held ##0
    (link_loss_reaction == sitm_pkg::STOP_PULSE_CUT) |-> torque_off_function)
    else $error("pulse cut not forced");
  a_comm_fail: assert property (s_lost_held |-> comm_failure)
    else $error("link loss not flagged");
  a_link_quiet: assert property ((!link_in_use || link_ok) [*3] |->
    stop_reaction == sitm_pkg::STOP_NONE) else $error("stray stop code");
  a_fault_set: assert property ($rose(internal_fault) |->
    ##[1:3] safety_fault) else $error("internal fault missed");
  a_first_event: assert property (safety_fault |->
    ##[0:2] internal_event) else $error("event flag missing");
  a_disc_hold: assert property (ext_torque_off_sel [*3] |->
    !discrepancy_fault) else $error("discrepancy not suspended");
  a_dir_unsel: assert property ((direction_unselected &&
    (encoder_present || switched_on)) [*3] |-> direction_guard)
    else $error("direction guard idle");
  a_speed_unsel: assert property ((speed_unselected &&
    (encoder_present || switched_on)) [*3] |-> limited_speed_guard)
    else $error("speed guard idle");
  a_due_alarm: assert property (test_due_alarm ==
    (basic_status_word[31] || extended_status_word[0]))
    else $error("no alarm");
  a_word_spare: assert property (basic_status_word[30:1] == 30'h0 &&
    extended_status_word[31:2] == 30'h0) else $error("spare bits set");
  a_due_reload: assert property ($fell(basic_status_word[31]) |->
    basic_time_left != 32'h0) else $error("due cleared without reload");
endmodule : sitm_top_chk

bind sitm_top sitm_top_chk #(.MS_CYCLES(MS_CYCLES)) u_sitm_top_chk (.*);

// file: sitm_partner.sv
// Far-side model: shutdown-path readback and safety link health.
// Assumes the bench commands link drops; answers on clk_sys.
`timescale 1ns/1ps
module sitm_partner #(
  parameter int RB_DELAY = 20
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic torque_off_function,
  input wire logic link_drop,
  input wire logic path_stuck,
  output logic readback_raw,
  output logic link_ok
);
  logic [RB_DELAY-1:0] path_q;
  ////////////////////////////////////////
  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      path_q <= '0;
      link_ok <= 1'b0;
    end else begin
      // Slow path: contactor opens some cycles after cutoff
      path_q <= {path_q[RB_DELAY-2:0], torque_off_function};
      // One controller, one destination: addresses unique by construction
      link_ok <= !link_drop;
    end
  end
  // Stuck path models a contactor that never opens, so the check fails
  assign readback_raw = path_q[RB_DELAY-1] && !path_stuck;
endmodule : sitm_partner

// file: tb.sv
// Self-checking bench for the safety input and test stop monitor.
// Bench plays the terminal sensors; partner closes readback and link.
`timescale 1ns/1ps
module tb;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [sitm_pkg::DI_N-1:0] di_term_a = '0, di_term_b = '0;
  logic [15:0] discrepancy_window = 16'h0005, input_filter_time = 16'h0000;
  logic [sitm_pkg::SRC_W-1:0] torque_off_source = 5'h1F;
  logic [sitm_pkg::SRC_W-1:0] stop_one_source = 5'h1F, brake_source = 5'h1F;
  logic link_in_use = 1'b0, link_drop = 1'b0, ext_torque_off_sel = 1'b0;
  logic path_stuck = 1'b0;
  logic ext_stop_one_sel = 1'b0, direction_unselected = 1'b0;
  logic direction_sel = 1'b0, speed_unselected = 1'b0, speed_sel = 1'b0;
  logic encoder_present = 1'b0, switched_on = 1'b0, fault_ack = 1'b0;
  logic test_trigger_source = 1'b0, auto_test_on_rampup = 1'b0;
  logic rampup_done = 1'b0, internal_fault = 1'b0, limit_violation = 1'b0;
  logic [2:0] link_loss_reaction = 3'h1;
  logic [31:0] basic_test_interval = 32'h1, extended_test_interval = 32'h2;
  logic readback_raw, link_ok, torque_off_function, ramped_stop_one;
  logic brake_control_safe, direction_guard, limited_speed_guard;
  logic discrepancy_fault, source_error, test_fail, safety_fault;
  logic internal_event, comm_failure, test_due_alarm;
  logic [2:0] stop_reaction;
  logic [31:0] basic_status_word, extended_status_word;
  logic [31:0] basic_time_left, extended_time_left;
  int n_errors = 0;
  int n_compared = 0;
  int i;
  // Short millisecond so a second is 10000 cycles
  sitm_top #(.MS_CYCLES(10)) u_sitm_top (.*);
  sitm_partner u_sitm_partner (.*);
  always #5 clk_sys = ~clk_sys;
  ////////////////////////////////////////
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      n_errors++;
      $display("CHECK FAILED %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic ck(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask : ck
  task automatic finish_test;
    if (n_errors == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : finish_test
  ////////////////////////////////////////
  task automatic t_sources;
    logic [4:0] s;
    logic ok;
    logic e;
    for (int k = 0; k < 64; k++) begin
      s = k[4:0];
      ok = s < 5'h08 || s == 5'h10 || s == 5'h11 || s == 5'h14 ||
           s == 5'h15 || s == 5'h1F;
      e = !ok || (k[5] && s != 5'h1F);
      @(posedge clk_sys);
      di_term_a <= {22{k[5]}};
      di_term_b <= {22{k[5]}};
      torque_off_source <= s;
      stop_one_source <= s;
      brake_source <= s;
      ck(6);
      chk("src_err", source_error, !ok);
      chk("select", {torque_off_function, ramped_stop_one,
          brake_control_safe}, {3{e}});
    end
    @(posedge clk_sys);
    di_term_a <= '0;
    di_term_b <= '0;
    torque_off_source <= 5'h00;
  endtask : t_sources
  task automatic t_filter;
    @(posedge clk_sys);
    input_filter_time <= 16'h00FA;
    repeat (8) @(posedge clk_sys);
    di_term_a[0] <= 1'b1;
    di_term_b[0] <= 1'b1;
    repeat (15) @(posedge clk_sys);
    di_term_a[0] <= 1'b0;
    di_term_b[0] <= 1'b0;
    ck(60);
    chk("glitch", torque_off_function, 1'b0);
    @(posedge clk_sys);
    di_term_a[0] <= 1'b1;
    di_term_b[0] <= 1'b1;
    ck(23);
    chk("early", torque_off_function, 1'b0);
    ck(11);
    chk("late", torque_off_function, 1'b1);
    @(posedge clk_sys);
    di_term_a[0] <= 1'b0;
    di_term_b[0] <= 1'b0;
    ck(60);
    @(posedge clk_sys);
    input_filter_time <= 16'h0000;
  endtask : t_filter
  task automatic t_disc;
    @(posedge clk_sys);
    di_term_a[1] <= 1'b1;
    ck(30);
    chk("disc_early", discrepancy_fault, 1'b0);
    ck(40);
    chk("disc", {discrepancy_fault, safety_fault, internal_event},
        3'h7);
    @(posedge clk_sys);
    di_term_b[1] <= 1'b1;
    di_term_a[2] <= 1'b1;
    ext_torque_off_sel <= 1'b1;
    ck(100);
    chk("disc_hold", discrepancy_fault, 1'b0);
    @(posedge clk_sys);
    di_term_a <= '0;
    di_term_b <= '0;
    ext_torque_off_sel <= 1'b0;
    for (int k = 0; k < 2; k++) begin
      fault_ack <= 1'b1;
      @(posedge clk_sys);
      fault_ack <= 1'b0;
      internal_fault <= !k[0];
      limit_violation <= k[0];
      ck(3);
      chk("fault", safety_fault, 1'b1);
      @(posedge clk_sys);
      internal_fault <= 1'b0;
      limit_violation <= 1'b0;
    end
    fault_ack <= 1'b1;
    @(posedge clk_sys);
    fault_ack <= 1'b0;
    ck(2);
    chk("ack", safety_fault, 1'b0);
  endtask : t_disc
  task automatic t_link;
    @(posedge clk_sys);
    link_in_use <= 1'b1;
    link_drop <= 1'b1;
    ck(6);
    chk("ramped", {comm_failure, stop_reaction},
        {1'b1, sitm_pkg::STOP_RAMPED});
    @(posedge clk_sys);
    link_loss_reaction <= sitm_pkg::STOP_PULSE_CUT;
    ck(4);
    chk("cut", {stop_reaction, torque_off_function},
        {sitm_pkg::STOP_PULSE_CUT, 1'b1});
    @(posedge clk_sys);
    link_drop <= 1'b0;
    ck(6);
    chk("link_ok", {comm_failure, stop_reaction},
        {1'b0, sitm_pkg::STOP_NONE});
  endtask : t_link
  task automatic t_guards;
    @(posedge clk_sys);
    direction_unselected <= 1'b1;
    speed_unselected <= 1'b1;
    for (int k = 0; k < 3; k++) begin
      @(posedge clk_sys);
      encoder_present <= (k == 2);
      switched_on <= (k == 1);
      ck(3);
      chk("guards", {direction_guard, limited_speed_guard},
          {2{k > 0}});
    end
  endtask : t_guards
  task automatic t_timer;
    for (i = 0; i < 12000 && basic_time_left !== 32'h0; i++)
      @(negedge clk_sys);
    ck(0);
    chk("b_zero", basic_time_left, 32'h0);
    @(posedge clk_sys);
    di_term_a[0] <= 1'b1;
    di_term_b[0] <= 1'b1;
    ck(5);
    @(posedge clk_sys);
    di_term_a[0] <= 1'b0;
    di_term_b[0] <= 1'b0;
    ck(6);
    chk("b_restart", basic_time_left, 32'h1);
    chk("e_restart", extended_time_left, 32'h2);
    for (i = 0; i < 25000 && basic_status_word[31] !== 1'b1; i++)
      @(negedge clk_sys);
    ck(200);
    chk("due", {basic_status_word[31], test_due_alarm},
        2'h3);
    for (int k = 0; k < 2; k++) begin
      @(posedge clk_sys);
      auto_test_on_rampup <= k[0];
      rampup_done <= k[0];
      test_trigger_source <= !k[0];
      ck(4);
      chk("run", {extended_status_word[1], torque_off_function},
          2'h3);
      @(posedge clk_sys);
      test_trigger_source <= 1'b0;
      for (i = 0; i < 3000 && extended_status_word[1] !== 1'b0; i++)
        @(negedge clk_sys);
      ck(3);
      chk("done", {test_fail, basic_status_word[31]}, 2'h0);
      chk("b_reload", basic_time_left, 32'h1);
    end
    @(posedge clk_sys);
    path_stuck <= 1'b1;
    auto_test_on_rampup <= 1'b0;
    test_trigger_source <= 1'b1;
    ck(4);
    chk("stuck_run", extended_status_word[1], 1'b1);
    for (i = 0; i < 3000 && extended_status_word[1] !== 1'b0; i++)
      @(negedge clk_sys);
    ck(3);
    chk("stuck", {test_fail, safety_fault}, 2'h3);
  endtask : t_timer
  ////////////////////////////////////////
  initial begin
    repeat (6) @(posedge clk_sys);
    sys_rst <= 1'b0;
    ck(2);
    chk("rst_stop", stop_reaction, sitm_pkg::STOP_NONE);
    chk("rst_words", basic_status_word | extended_status_word,
        32'h0);
    chk("load_b", basic_time_left, 32'h1);
    chk("load_e", extended_time_left, 32'h2);
    t_sources;
    t_filter;
    t_disc;
    t_link;
    t_guards;
    t_timer;
    finish_test;
  end
  initial begin
    repeat (90000) @(posedge clk_sys);
    n_errors++;
    finish_test;
  end
endmodule : tb
